//--- usd_pkg.sv
// constants, types and register map of the usb suspend/stall/endpoint block
package usd_pkg;

  // clock and line timing
  localparam int unsigned CLK_KHZ        = 200000;
  localparam int unsigned SUSP_IDLE_MS   = 3;
  localparam int unsigned RWAKE_IDLE_MS  = 5;
  localparam int unsigned RESUME_DRV_MS  = 2;
  localparam int unsigned SUSP_IDLE_CYC  = SUSP_IDLE_MS * CLK_KHZ;
  localparam int unsigned RWAKE_IDLE_CYC = RWAKE_IDLE_MS * CLK_KHZ;
  localparam int unsigned RESUME_DRV_CYC = RESUME_DRV_MS * CLK_KHZ;
  localparam int          CNT_W          = 21;

  // register map, byte addresses
  localparam int                  AW      = 5;
  localparam logic [AW-1:0]       A_CTRL  = 5'h00;
  localparam logic [AW-1:0]       A_GFLAG = 5'h04;
  localparam logic [AW-1:0]       A_GEN   = 5'h08;
  localparam logic [1:0][AW-1:0]  A_EP    = {5'h10, 5'h0C};
  localparam logic [1:0][AW-1:0]  A_DAT   = {5'h18, 5'h14};

  // control register bits
  localparam int C_DETACH = 0;
  localparam int C_RWAKE  = 1;
  localparam int C_LSM    = 2;
  localparam int C_FRZ    = 3;

  // general flag / enable bits, status bits in the flag register
  localparam int G_W     = 4;
  localparam int G_SUSP  = 0;
  localparam int G_WAKE  = 1;
  localparam int G_EORSM = 2;
  localparam int G_UPRSM = 3;
  localparam int G_SUSPD = 8;
  localparam int G_FS    = 9;
  localparam int G_RDRV  = 10;

  // endpoint register bits
  localparam int NEPF      = 5;
  localparam int E_TXIN    = 0;
  localparam int E_STALLED = 1;
  localparam int E_RXOUT   = 2;
  localparam int E_RXSTP   = 3;
  localparam int E_NAKIN   = 4;
  localparam int E_RDOK    = 5;
  localparam int E_BCTL    = 6;
  localparam int E_STL_REQ = 7;
  localparam int E_STALLRC = 8;
  localparam int E_EN_LO   = 16;
  localparam int E_BC_LO   = 24;

  // banks: 0 and 1 ping-pong for the out endpoint, 2 for the control endpoint
  localparam int                NBANK   = 3;
  localparam int                DEPTH   = 16;
  localparam int                PTR_W   = 5;
  localparam logic [PTR_W-1:0]  DEPTH_P = 5'h10;
  localparam logic [1:0]        BK_CTL  = 2'h2;
  localparam logic              EP_CTL  = 1'b0;

  typedef enum logic [1:0] {
    PID_OUT   = 2'h0,
    PID_IN    = 2'h1,
    PID_SETUP = 2'h2
  } usd_pid_e;

  typedef enum logic [1:0] {
    HS_ACK   = 2'h0,
    HS_NAK   = 2'h1,
    HS_STALL = 2'h2,
    HS_DATA  = 2'h3
  } usd_hs_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RX   = 3'b010,
    ST_DROP = 3'b100
  } usd_st_e;

  typedef struct packed {
    logic     valid;
    usd_pid_e pid;
    logic     ep;
    logic     retry;
  } usd_tok_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       done;
  } usd_rx_s;

  typedef struct packed {
    logic    valid;
    usd_hs_e code;
  } usd_hs_s;

endpackage : usd_pkg

//--- usd_core.sv
// usb device suspend, remote wake-up, stall and endpoint bank control
// Functional notes
// - after 3 ms idle line, force full speed and set suspend flag
// - clearing clock freeze leaves suspend and restarts transfers
// - any non-idle line pattern sets wake flag, suspended or not, except while the device drives resume
// - wake set clears suspend flag; suspend set clears wake flag
// - disconnect bit resets to 1, device starts detached
// - disconnect removes pull-up on D+ (full) or D- (low speed)
// - upstream resume only sent while suspend flag is set
// - with remote wake request set, resume starts after 5 ms idle
// - resume start sets upstream resume flag and clears suspend flag
// - remote wake request self-clears when resume signalling ends
// - valid end-of-resume from host sets end-of-resume flag
// - stall request answers every following request with STALL, except retries and setup on the control endpoint
// - stall-clear write clears stall request; stall-clear reads 0
// - each STALL sets stall-sent; packet dropped, no out flag, no rw
// - setup on stalled control endpoint acked, clears stall state
// - retry beats stall; STALL only when no retry pending
// - setup sets setup flag only; firmware clears empty bank or send
// - control endpoint bank control and rw-allowed read 0
// - control read: first status token NAK, then cpu data ignored
// - control read out retry acked, sets out and in-free flags
// - zero-length out on control endpoint resets its byte count; out endpoint keeps current bank count
// - full out bank sets flag and bank control; clear swaps bank
// - rw-allowed set while current out bank holds unread data
// - clock freeze stops engine, wake detection keeps running
//
// Our own choices: the address map and the Avalon-MM slave port.
module usd_core
  import usd_pkg::*;
#(
  parameter int unsigned SUSP_CYC   = SUSP_IDLE_CYC,
  parameter int unsigned RWAKE_CYC  = RWAKE_IDLE_CYC,
  parameter int unsigned RESUME_CYC = RESUME_DRV_CYC
) (
  input  wire logic          clock,
  input  wire logic          reset_n,
  input  wire logic          ce,
  input  wire logic [AW-1:0] avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [31:0]   avs_writedata,
  input  wire logic [3:0]    avs_byteenable,
  output logic      [31:0]   avs_readdata,
  output logic               avs_waitrequest,
  input  wire logic          line_idle,
  input  wire logic          line_nonidle,
  input  wire logic          eor_detect,
  input  wire usd_tok_s      tok,
  input  wire usd_rx_s       rx,
  output usd_hs_s            hs,
  output logic               pullup_dp,
  output logic               pullup_dm,
  output logic               resume_drive,
  output logic               full_speed,
  output logic               suspended,
  output logic               gen_irq,
  output logic      [1:0]    endpoint_irq
);

  localparam logic [CNT_W-1:0] SUSP_CNT   = CNT_W'(SUSP_CYC);
  localparam logic [CNT_W-1:0] RWAKE_CNT  = CNT_W'(RWAKE_CYC);
  localparam logic [CNT_W-1:0] RESUME_CNT = CNT_W'(RESUME_CYC);

  typedef struct packed {
    logic                                   wreq;
    logic [31:0]                            rdata;
    logic                                   detach;
    logic                                   rwake;
    logic                                   lsm;
    logic                                   frz;
    logic [G_W-1:0]                         gfl;
    logic [G_W-1:0]                         gen;
    logic                                   susp_st;
    logic                                   fs_mode;
    logic                                   rdrv;
    logic [CNT_W-1:0]                       idle_cnt;
    logic [CNT_W-1:0]                       res_cnt;
    logic [1:0][NEPF-1:0]                   epf;
    logic [1:0][NEPF-1:0]                   epe;
    logic [1:0]                             stall_rq;
    logic                                   bankctl;
    logic [1:0]                             full;
    logic                                   cb;
    logic                                   fb;
    logic                                   saw_in;
    logic                                   stat;
    logic [NBANK-1:0][DEPTH-1:0][7:0]       mem;
    logic [NBANK-1:0][PTR_W-1:0]            wp;
    logic [NBANK-1:0][PTR_W-1:0]            rp;
    usd_st_e                                st;
    logic                                   tep;
    usd_pid_e                               tpid;
    logic [1:0]                             rb;
    usd_hs_e                                pend;
    usd_hs_s                                hs;
    logic                                   pu_dp;
    logic                                   pu_dm;
    logic                                   irq;
    logic [1:0]                             ep_irq;
  } usd_state_s;

  localparam usd_state_s ST_RST = '{
    wreq: 1'b1, detach: 1'b1, frz: 1'b1, st: ST_IDLE, tpid: PID_OUT,
    pend: HS_ACK, hs: '{valid: 1'b0, code: HS_ACK}, default: '0};

  usd_state_s      s_r;
  usd_state_s      s_nxt;
  logic [31:0]     rv;
  logic [31:0]     wd;
  logic            acc;
  logic            wr;
  logic [1:0]      bk [2];
  logic [NEPF-1:0] clr;
  logic            rd_ok;
  logic            ev_susp;

  always_comb begin
    s_nxt   = s_r;
    rv      = '0;
    clr     = '0;
    bk[0]   = BK_CTL;
    bk[1]   = {1'b0, s_r.cb};
    rd_ok   = s_r.full[s_r.cb] && (s_r.wp[bk[1]] != s_r.rp[bk[1]]);
    ev_susp = 1'b0;
    wd      = avs_writedata & {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                               {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    acc     = (avs_read | avs_write) & ~s_r.wreq;
    wr      = acc & avs_write;
    s_nxt.hs.valid = 1'b0;

    // read mux, unmapped addresses read zero
    case (avs_address)
      A_CTRL: begin
        rv[C_DETACH] = s_r.detach;
        rv[C_RWAKE]  = s_r.rwake;
        rv[C_LSM]    = s_r.lsm;
        rv[C_FRZ]    = s_r.frz;
      end
      A_GFLAG: begin
        rv[G_W-1:0] = s_r.gfl;
        rv[G_SUSPD] = s_r.susp_st;
        rv[G_FS]    = s_r.fs_mode;
        rv[G_RDRV]  = s_r.rdrv;
      end
      A_GEN: rv[G_W-1:0] = s_r.gen;
      default: rv = '0;
    endcase
    for (int e = 0; e < 2; e++) begin
      if (avs_address == A_EP[e]) begin
        rv[NEPF-1:0]           = s_r.epf[e];
        rv[E_RDOK]             = (e == 1) && rd_ok;
        rv[E_BCTL]             = (e == 1) && s_r.bankctl;
        rv[E_STL_REQ]          = s_r.stall_rq[e];
        rv[E_EN_LO +: NEPF]    = s_r.epe[e];
        rv[E_BC_LO +: PTR_W]   = s_r.wp[bk[e]] - s_r.rp[bk[e]];
      end
      if (avs_address == A_DAT[e]) begin
        rv[7:0] = s_r.mem[bk[e]][s_r.rp[bk[e]][PTR_W-2:0]];
      end
    end

    // slave answers on the second edge: wreq drops, then the access is taken
    s_nxt.wreq = ~((avs_read | avs_write) & s_r.wreq);
    if ((avs_read | avs_write) & s_r.wreq) begin
      s_nxt.rdata = rv;
    end

    if (wr && avs_address == A_CTRL && avs_byteenable[0]) begin
      s_nxt.detach = wd[C_DETACH];
      s_nxt.lsm    = wd[C_LSM];
      s_nxt.frz    = wd[C_FRZ];
      if (wd[C_RWAKE]) begin
        s_nxt.rwake = 1'b1;
      end
      if (s_r.frz && !wd[C_FRZ]) begin
        s_nxt.susp_st = 1'b0;
      end
    end
    if (wr && avs_address == A_GFLAG) begin
      s_nxt.gfl = s_r.gfl & ~wd[G_W-1:0];
    end
    if (wr && avs_address == A_GEN && avs_byteenable[0]) begin
      s_nxt.gen = wd[G_W-1:0];
    end
    for (int e = 0; e < 2; e++) begin
      if (wr && avs_address == A_EP[e]) begin
        clr = wd[NEPF-1:0];
        if (e == 0 && s_r.stat) begin
          clr[E_TXIN] = 1'b0;
        end
        s_nxt.epf[e] = s_r.epf[e] & ~clr;
        if (e == 0 && (clr[E_RXOUT] || clr[E_RXSTP])) begin
          s_nxt.wp[BK_CTL] = '0;
          s_nxt.rp[BK_CTL] = '0;
        end
        if (wd[E_STL_REQ]) begin
          s_nxt.stall_rq[e] = 1'b1;
        end
        if (wd[E_STALLRC]) begin
          s_nxt.stall_rq[e] = 1'b0;
        end
        if (avs_byteenable[2]) begin
          s_nxt.epe[e] = wd[E_EN_LO +: NEPF];
        end
        if (e == 1 && wd[E_BCTL] && s_r.bankctl) begin
          s_nxt.full[s_r.cb]         = 1'b0;
          s_nxt.wp[bk[1]]            = '0;
          s_nxt.rp[bk[1]]            = '0;
          s_nxt.cb                   = ~s_r.cb;
          s_nxt.bankctl              = s_r.full[~s_r.cb];
          s_nxt.epf[1][E_RXOUT]      = s_r.full[~s_r.cb];
        end
      end
      if (acc && avs_read && avs_address == A_DAT[e]
          && s_r.wp[bk[e]] != s_r.rp[bk[e]]) begin
        s_nxt.rp[bk[e]] = s_r.rp[bk[e]] + 1'b1;
      end
    end
    // cpu data for the control endpoint is dropped once status is seen
    if (wr && avs_address == A_DAT[0] && !s_r.stat && s_r.wp[BK_CTL] < DEPTH_P) begin
      s_nxt.mem[BK_CTL][s_r.wp[BK_CTL][PTR_W-2:0]] = wd[7:0];
      s_nxt.wp[BK_CTL] = s_r.wp[BK_CTL] + 1'b1;
    end

    // suspend and remote wake-up timing; hardware sets come after clears
    if (!s_r.frz) begin
      if (!line_idle || s_r.rdrv) begin
        s_nxt.idle_cnt = '0;
      end else if (s_r.idle_cnt != RWAKE_CNT) begin
        s_nxt.idle_cnt = s_r.idle_cnt + 1'b1;
      end
      ev_susp = (s_nxt.idle_cnt == SUSP_CNT) && (s_r.idle_cnt != SUSP_CNT);
      if (ev_susp) begin
        s_nxt.gfl[G_SUSP] = 1'b1;
        s_nxt.gfl[G_WAKE] = 1'b0;
        s_nxt.fs_mode     = 1'b1;
        s_nxt.susp_st     = 1'b1;
      end
      if (s_r.rdrv) begin
        s_nxt.res_cnt = s_r.res_cnt + 1'b1;
        if (s_r.res_cnt == RESUME_CNT - 1'b1) begin
          s_nxt.rdrv  = 1'b0;
          s_nxt.rwake = 1'b0;
        end
      end else if (s_r.rwake && s_r.gfl[G_SUSP] && s_r.idle_cnt == RWAKE_CNT) begin
        s_nxt.rdrv          = 1'b1;
        s_nxt.res_cnt       = '0;
        s_nxt.gfl[G_UPRSM]  = 1'b1;
        s_nxt.gfl[G_SUSP]   = 1'b0;
      end
    end
    // own resume drive is not a wake-up source
    if (line_nonidle && !s_r.rdrv) begin
      s_nxt.gfl[G_WAKE] = 1'b1;
      s_nxt.gfl[G_SUSP] = 1'b0;
      s_nxt.susp_st     = 1'b0;
      s_nxt.fs_mode     = 1'b0;
    end
    if (eor_detect) begin
      s_nxt.gfl[G_EORSM] = 1'b1;
    end

    // transaction engine, halted by clock freeze
    if (!s_r.frz) begin
      case (s_r.st)
        ST_IDLE: begin
          if (tok.valid) begin
            s_nxt.tep  = tok.ep;
            s_nxt.tpid = tok.pid;
            if (tok.ep == EP_CTL && tok.pid == PID_SETUP) begin
              s_nxt.st         = ST_RX;
              s_nxt.rb         = BK_CTL;
              s_nxt.wp[BK_CTL] = '0;
              s_nxt.rp[BK_CTL] = '0;
            end else if (tok.retry || s_r.stall_rq[tok.ep]) begin
              s_nxt.pend = tok.retry ? HS_NAK : HS_STALL;
              if (tok.pid == PID_IN) begin
                s_nxt.hs.valid = 1'b1;
                s_nxt.hs.code  = s_nxt.pend;
                if (!tok.retry) begin
                  s_nxt.epf[tok.ep][E_STALLED] = 1'b1;
                end
              end else begin
                s_nxt.st = ST_DROP;
              end
            end else if (tok.pid == PID_IN) begin
              s_nxt.hs.valid = 1'b1;
              if (tok.ep == EP_CTL && !s_nxt.epf[0][E_TXIN] && !s_r.stat) begin
                s_nxt.hs.code      = HS_DATA;
                s_nxt.epf[0][E_TXIN] = 1'b1;
                s_nxt.wp[BK_CTL]   = '0;
                s_nxt.rp[BK_CTL]   = '0;
                s_nxt.saw_in       = 1'b1;
              end else begin
                s_nxt.hs.code              = HS_NAK;
                s_nxt.epf[tok.ep][E_NAKIN] = 1'b1;
              end
            end else if (tok.ep == EP_CTL) begin
              if (s_r.saw_in && !s_r.stat) begin
                s_nxt.stat = 1'b1;
                s_nxt.pend = HS_NAK;
                s_nxt.st   = ST_DROP;
              end else if (!s_r.saw_in
                           && (s_nxt.epf[0][E_RXOUT] || s_nxt.epf[0][E_RXSTP])) begin
                s_nxt.pend = HS_NAK;
                s_nxt.st   = ST_DROP;
              end else begin
                s_nxt.st         = ST_RX;
                s_nxt.rb         = BK_CTL;
                s_nxt.wp[BK_CTL] = '0;
                s_nxt.rp[BK_CTL] = '0;
              end
            end else if (s_nxt.full[s_r.fb]) begin
              s_nxt.pend = HS_NAK;
              s_nxt.st   = ST_DROP;
            end else begin
              s_nxt.st = ST_RX;
              s_nxt.rb = {1'b0, s_r.fb};
            end
          end
        end
        ST_RX: begin
          if (rx.valid && s_r.wp[s_r.rb] < DEPTH_P) begin
            s_nxt.mem[s_r.rb][s_r.wp[s_r.rb][PTR_W-2:0]] = rx.data;
            s_nxt.wp[s_r.rb] = s_r.wp[s_r.rb] + 1'b1;
          end
          if (rx.done) begin
            s_nxt.st       = ST_IDLE;
            s_nxt.hs.valid = 1'b1;
            s_nxt.hs.code  = HS_ACK;
            if (s_r.tep == EP_CTL && s_r.tpid == PID_SETUP) begin
              s_nxt.stall_rq[0] = 1'b0;
              s_nxt.epf[0]     = '0;
              s_nxt.epf[0][E_RXSTP] = 1'b1;
              s_nxt.saw_in     = 1'b0;
              s_nxt.stat       = 1'b0;
            end else if (s_r.tep == EP_CTL) begin
              s_nxt.epf[0][E_RXOUT] = 1'b1;
              if (s_r.saw_in) begin
                s_nxt.epf[0][E_TXIN] = 1'b1;
              end
            end else begin
              s_nxt.full[s_r.rb[0]] = 1'b1;
              s_nxt.fb              = ~s_r.fb;
              if (s_r.rb[0] == s_nxt.cb) begin
                s_nxt.epf[1][E_RXOUT] = 1'b1;
                s_nxt.bankctl         = 1'b1;
              end
            end
          end
        end
        ST_DROP: begin
          if (rx.done) begin
            s_nxt.st       = ST_IDLE;
            s_nxt.hs.valid = 1'b1;
            s_nxt.hs.code  = s_r.pend;
            if (s_r.pend == HS_STALL) begin
              s_nxt.epf[s_r.tep][E_STALLED] = 1'b1;
            end
          end
        end
        default: s_nxt.st = ST_IDLE;
      endcase
    end

    s_nxt.pu_dp = ~s_nxt.detach & ~s_nxt.lsm;
    s_nxt.pu_dm = ~s_nxt.detach & s_nxt.lsm;
    s_nxt.irq   = |(s_nxt.gfl & s_nxt.gen);
    for (int e = 0; e < 2; e++) begin
      s_nxt.ep_irq[e] = |(s_nxt.epf[e] & s_nxt.epe[e]);
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s_r <= ST_RST;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata    = s_r.rdata;
  assign avs_waitrequest = s_r.wreq;
  assign hs              = s_r.hs;
  assign pullup_dp       = s_r.pu_dp;
  assign pullup_dm       = s_r.pu_dm;
  assign resume_drive    = s_r.rdrv;
  assign full_speed      = s_r.fs_mode;
  assign suspended       = s_r.susp_st;
  assign gen_irq         = s_r.irq;
  assign endpoint_irq    = s_r.ep_irq;

endmodule : usd_core

//--- usd_core_props.sv
// port-level checker for the usb suspend/stall/endpoint block
module usd_core_props
  import usd_pkg::*;
#(
  parameter int unsigned SUSP_CYC   = 30,
  parameter int unsigned RESUME_CYC = 20
) (
  input wire logic          clock,
  input wire logic          reset_n,
  input wire logic [AW-1:0] avs_address,
  input wire logic          avs_read,
  input wire logic [31:0]   avs_readdata,
  input wire logic          avs_waitrequest,
  input wire logic          line_idle,
  input wire usd_tok_s      tok,
  input wire usd_rx_s       rx,
  input wire usd_hs_s       hs,
  input wire logic          pullup_dp,
  input wire logic          pullup_dm,
  input wire logic          resume_drive,
  input wire logic          full_speed
);
  int unsigned icnt_r;
  int unsigned rcnt_r;
  usd_tok_s    tok_r;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      icnt_r <= 0;
      rcnt_r <= 0;
      tok_r  <= '0;
    end else begin
      icnt_r <= line_idle ? icnt_r + 1 : 0;
      rcnt_r <= resume_drive ? rcnt_r + 1 : 0;
      if (tok.valid) tok_r <= tok;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_attach_reset: assert property ($rose(reset_n) |-> !pullup_dp && !pullup_dm)
    else $error("pull-up active right after reset");
  a_one_pullup: assert property (!(pullup_dp && pullup_dm))
    else $error("both pull-ups active");
  a_susp_idle: assert property ($rose(full_speed) |-> icnt_r >= SUSP_CYC - 1)
    else $error("suspend seen before idle time ran out");
  a_resume_susp: assert property ($rose(resume_drive) |-> $past(full_speed))
    else $error("resume driven outside suspend");
  a_resume_len: assert property (
    $fell(resume_drive) |-> rcnt_r inside {[RESUME_CYC - 1 : RESUME_CYC + 1]})
    else $error("resume drive length wrong");
  a_stall_clr_rd: assert property (
    !avs_waitrequest && avs_read && (avs_address == A_EP[0] || avs_address == A_EP[1])
    |-> !avs_readdata[E_STALLRC])
    else $error("stall clear bit read as set");
  a_ctl_bits_zero: assert property (
    !avs_waitrequest && avs_read && avs_address == A_EP[0] |-> avs_readdata[E_RDOK +: 2] == 2'h0)
    else $error("control endpoint bank bits not zero");
  a_setup_ack: assert property (
    rx.done && tok_r.pid == PID_SETUP && tok_r.ep == EP_CTL |=> hs.valid && hs.code == HS_ACK)
    else $error("setup not acknowledged");
endmodule : usd_core_props

//--- usd_host.sv
// host model: line states, tokens and packet bytes toward the device
module usd_host
  import usd_pkg::*;
(
  input  wire logic    clock,
  input  wire usd_hs_s hs,
  input  wire logic    resume_drive,
  output logic         line_idle,
  output logic         line_nonidle,
  output logic         eor_detect,
  output usd_tok_s     tok,
  output usd_rx_s      rx
);
  logic idle_r;

  // line shows k, not j, while the device drives resume
  assign line_idle = idle_r & ~resume_drive;

  initial begin
    idle_r       = 1'b0;
    line_nonidle = 1'b0;
    eor_detect   = 1'b0;
    tok          = '0;
    rx           = '0;
  end

  task automatic drive(input int n, input logic i, input logic w, input logic e);
    idle_r       <= i;
    line_nonidle <= w;
    eor_detect   <= e;
    repeat (n) @(posedge clock);
    {idle_r, line_nonidle, eor_detect} <= 3'h0;
  endtask : drive

  // ok low: no handshake came back within the wait
  task automatic xfer(input usd_pid_e p, input logic e, input logic r, input int n,
                      output logic ok, output usd_hs_e c);
    @(posedge clock);
    tok <= '{1'b1, p, e, r};
    @(posedge clock);
    tok.valid <= 1'b0;
    if (p != PID_IN) begin
      for (int i = 0; i < n; i++) begin
        rx <= '{1'b1, 8'(8'h30 + i), 1'b0};
        @(posedge clock);
      end
      // data line no longer carries the last byte
      rx <= '{1'b0, ~rx.data, 1'b1};
      @(posedge clock);
      rx.done <= 1'b0;
    end
    ok = 1'b0;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(posedge clock);
      ok = hs.valid === 1'b1;
      c  = hs.code;
    end
  endtask : xfer
endmodule : usd_host

//--- usd_core_bench.sv
// self-checking bench for the usb suspend/stall/endpoint block
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %0t got %h exp %h", $time, (g), (e)); end end

module usd_core_bench
  import usd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned SC = 30;
  localparam int unsigned RC = 20;
  logic          clock = 1'b0;
  logic          reset_n = 1'b0;
  logic          ce = 1'b1;
  logic [AW-1:0] avs_address = '0;
  logic          avs_read = 1'b0;
  logic          avs_write = 1'b0;
  logic [31:0]   avs_writedata = '0;
  logic [31:0]   avs_readdata;
  logic          avs_waitrequest;
  logic          line_idle, line_nonidle, eor_detect;
  usd_tok_s      tok;
  usd_rx_s       rx;
  usd_hs_s       hs;
  logic          pullup_dp, pullup_dm, resume_drive, full_speed, suspended, gen_irq;
  logic [1:0]    endpoint_irq;
  logic [31:0]   d;
  logic          ok;
  usd_hs_e       c;
  int            bad_count = 0;
  int            n_tests = 0;

  always #2.5 clock = ~clock;

  usd_core #(.SUSP_CYC(SC), .RWAKE_CYC(50), .RESUME_CYC(RC)) uut (
    .ce(ce), .avs_byteenable(4'hF), .*);
  usd_host host (.*);

  task automatic finish_test;
    $display("mismatches %0d of %0d checks", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test

  task automatic bus(input logic wr, input logic [AW-1:0] a, input logic [31:0] wd);
    int i;
    @(posedge clock);
    avs_address   <= a;
    avs_writedata <= wd;
    avs_write     <= wr;
    avs_read      <= !wr;
    for (i = 0; i < 10 && avs_waitrequest !== 1'b0; i++) @(posedge clock);
    // a hang counts as a mismatch; the run goes on to the verdict
    if (i == 10) begin
      bad_count++;
    end
    d = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic pkt(input usd_pid_e p, input logic e, input logic r, input int n,
                     input usd_hs_e x);
    host.xfer(p, e, r, n, ok, c);
    if (!ok) begin
      bad_count++;
    end
    `CHK(c, x)
  endtask : pkt

  task automatic t_reset;
    logic [3:0] cv[4] = '{4'h0, 4'h4, 4'h5, 4'h1};
    logic [1:0] pv[4] = '{2'h2, 2'h1, 2'h0, 2'h0};
    bus(0, A_CTRL, 0);
    `CHK(d[3:0], 4'h9)
    `CHK({pullup_dp, pullup_dm}, 2'h0)
    host.xfer(PID_IN, EP_CTL, 1'b0, 0, ok, c);
    `CHK(ok, 1'b0)
    for (int k = 0; k < 4; k++) begin
      bus(1, A_CTRL, {28'h000_0000, cv[k]});
      bus(0, A_CTRL, 0);
      `CHK({pullup_dp, pullup_dm}, pv[k])
    end
    bus(1, A_CTRL, 32'h0000_0000);
  endtask : t_reset

  task automatic t_stall;
    bus(1, A_EP[1], 32'h0002_0080);
    pkt(PID_OUT, 1'b1, 1'b0, 2, HS_STALL);
    pkt(PID_OUT, 1'b1, 1'b0, 1, HS_STALL);
    pkt(PID_OUT, 1'b1, 1'b1, 1, HS_NAK);
    bus(0, A_EP[1], 0);
    `CHK(d[7:0] & 8'hA6, 8'h82)
    `CHK(endpoint_irq, 2'h2)
    bus(1, A_EP[1], 32'h0000_0102);
    bus(0, A_EP[1], 0);
    `CHK({d[8:7], d[1]}, 3'h0)
    pkt(PID_OUT, 1'b1, 1'b0, 3, HS_ACK);
  endtask : t_stall

  task automatic t_out;
    pkt(PID_OUT, 1'b1, 1'b0, 0, HS_ACK);
    bus(0, A_EP[1], 0);
    `CHK({d[28:24], d[6:5], d[2]}, 8'h1F)
    for (int k = 0; k < 3; k++) begin
      bus(0, A_DAT[1], 0);
      `CHK(d[7:0], 8'(8'h30 + k))
    end
    bus(0, A_EP[1], 0);
    `CHK(d[5], 1'b0)
    // out flag first, then free the bank
    bus(1, A_EP[1], 32'h0000_0004);
    bus(1, A_EP[1], 32'h0000_0040);
    bus(0, A_EP[1], 0);
    `CHK({d[28:24], d[6], d[2]}, 7'h03)
  endtask : t_out

  task automatic t_ctrl;
    bus(1, A_EP[0], 32'h0000_0080);
    pkt(PID_IN, EP_CTL, 1'b0, 0, HS_STALL);
    pkt(PID_SETUP, EP_CTL, 1'b0, 8, HS_ACK);
    bus(0, A_EP[0], 0);
    `CHK(d[7:0], 8'h08)
    bus(1, A_EP[0], 32'h0000_0008);
    bus(1, A_DAT[0], 32'h0000_00A5);
    bus(1, A_EP[0], 32'h0000_0001);
    pkt(PID_IN, EP_CTL, 1'b0, 0, HS_DATA);
    pkt(PID_OUT, EP_CTL, 1'b0, 0, HS_NAK);
    bus(1, A_DAT[0], 32'h0000_005A);
    bus(0, A_EP[0], 0);
    `CHK(d[28:24], 5'h00)
    pkt(PID_OUT, EP_CTL, 1'b0, 0, HS_ACK);
    bus(0, A_EP[0], 0);
    `CHK({d[28:24], d[2], d[0]}, 7'h03)
    bus(1, A_EP[0], 32'h0000_0001);
    bus(0, A_EP[0], 0);
    `CHK(d[0], 1'b1)
    pkt(PID_IN, EP_CTL, 1'b0, 0, HS_NAK);
  endtask : t_ctrl

  task automatic t_susp;
    bus(1, A_GEN, 32'h0000_0001);
    host.drive(SC + 5, 1'b1, 1'b0, 1'b0);
    bus(0, A_GFLAG, 0);
    `CHK({d[9:8], d[3:0], gen_irq}, 7'h63)
    bus(1, A_CTRL, 32'h0000_0008);
    bus(1, A_CTRL, 32'h0000_0000);
    bus(0, A_GFLAG, 0);
    `CHK(d[8], 1'b0)
    `CHK(suspended, 1'b0)
    host.drive(1, 1'b0, 1'b1, 1'b0);
    bus(0, A_GFLAG, 0);
    `CHK({d[9], d[1:0]}, 3'h2)
    host.drive(SC + 5, 1'b1, 1'b0, 1'b0);
    bus(0, A_GFLAG, 0);
    `CHK(d[1:0], 2'h1)
    // resume ends well before idle could suspend again
    bus(1, A_CTRL, 32'h0000_0002);
    host.drive(85, 1'b1, 1'b0, 1'b0);
    bus(0, A_GFLAG, 0);
    `CHK({d[3], d[0]}, 2'h2)
    bus(0, A_CTRL, 0);
    `CHK(d[1], 1'b0)
    // a pulse seen while the enable is low must be lost
    ce <= 1'b0;
    host.drive(1, 1'b0, 1'b0, 1'b1);
    ce <= 1'b1;
    bus(0, A_GFLAG, 0);
    `CHK(d[2], 1'b0)
    host.drive(1, 1'b0, 1'b0, 1'b1);
    bus(0, A_GFLAG, 0);
    `CHK(d[2], 1'b1)
  endtask : t_susp

  initial begin
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    t_reset;
    t_stall;
    t_out;
    t_ctrl;
    t_susp;
    finish_test;
  end
endmodule : usd_core_bench

bind usd_core usd_core_props #(.SUSP_CYC(SUSP_CYC), .RESUME_CYC(RESUME_CYC)) chk (.*);
